//--- hdl/cbgf_pkg.sv
// Purpose: Shared constants for the butterfly and Galois accumulate unit.
// Assumes: Byte addresses on a 32-bit register bus, one word per register.
// Notes:   Every offset, register field position and status, control and interrupt reset value is named here once.
package cbgf_pkg;

  // Register map, byte addresses.
  localparam logic [5:0]  VREG_BASE_OFS = 6'h00;
  localparam logic [5:0]  VREG_LAST_OFS = 6'h1c;
  localparam logic [5:0]  STATUS_OFS    = 6'h20;
  localparam logic [5:0]  IRQ_STAT_OFS  = 6'h24;
  localparam logic [5:0]  IRQ_MASK_OFS  = 6'h28;
  localparam logic [5:0]  CTRL_OFS      = 6'h2c;

  // Fields of vector_status_reg.
  localparam int          ST_SAT        = 0;
  localparam int          ST_RND        = 1;
  localparam int          ST_COMPLEX_PACK_ORDER_SEL      = 2;
  localparam int          ST_REAL_OVERFLOW_FLAG       = 3;
  localparam int          ST_IMAG_OVERFLOW_FLAG       = 4;
  localparam int          ST_W          = 5;
  localparam logic [4:0]  STATUS_RST    = 5'h00;

  // Control register: the butterfly shift immediate.
  localparam int          CTRL_SHIFT    = 0;
  localparam logic [0:0]  CTRL_RST      = 1'h1;

  // Interrupt event bits.
  localparam int          EV_REAL_OVERFLOW_FLAG       = 0;
  localparam int          EV_IMAG_OVERFLOW_FLAG       = 1;
  localparam int          EV_BADOP      = 2;
  localparam int          EV_W          = 3;
  localparam logic [2:0]  IRQ_RST       = 3'h0;

  // Instruction encodings; the upper halfword sits in bits 31:16.
  localparam logic [15:0] BFLY_LSW      = 16'he2b0;
  localparam logic [7:0]  BFLY_MSW_TOP  = 8'h09;
  localparam logic [15:0] GFACC_LSW     = 16'he681;
  localparam logic [5:0]  GFACC_MSW_TOP = 6'h00;
  localparam int          GF_DST_LSB    = 7;
  localparam int          GF_SRC_LSB    = 4;

  // Signed 16-bit limits and the rounding increment.
  localparam logic [15:0] SAT_MAX       = 16'h7fff;
  localparam logic [15:0] SAT_MIN       = 16'h8000;
  localparam logic [15:0] RND_ONE       = 16'h0001;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_e;

endpackage : cbgf_pkg

//--- hdl/complex_butterfly_gf_accumulate.sv
// Purpose: Executes the final butterfly step with parallel word load and
//          the immediate Galois byte accumulate, in one cycle each.
// Assumes: The pipeline resolves the memory operand and presents it with
//          the instruction; bus registers are reached over Avalon-MM.
// Notes:   Vector registers and status are flip-flops readable by the bus.
//
// Summary of operation
// - Complex word holds imaginary in bits 31:16, real in bits 15:0.
// - Butterfly ignores the complex pack order select bit.
// - Butterfly-with-load decoded from fixed low halfword and fixed top byte.
// - Six/seven results from upper halves, each shifted by immediate.
// - Saturate enable clamps each sum or difference before shifting.
// - Round enable rounds shifted results; both enables independent.
// - Every right shift is arithmetic, copying the sign bit.
// - Addressed memory word loads into vector register zero alongside.
// - Overflow into a real half sets the real overflow flag.
// - Overflow into an imaginary half sets the imaginary overflow flag.
// - Butterfly and load finish in one cycle for the next instruction.
// - Accumulate decoded from fixed halfword; fields dest, source, imm.
// - Each set immediate bit XORs source byte i into destination byte.
// - Accumulate leaves every status flag unchanged.
// - Accumulate completes in one cycle.
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module complex_butterfly_gf_accumulate
  import cbgf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] word_mem_operand,
  output logic             instr_done,
  output logic             instr_bad,
  output logic      [7:0]  mem_addr,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  logic [31:0]      vreg_q [8];
  logic [ST_W-1:0]  vector_status_reg;
  logic [EV_W-1:0]  irq_stat_q;
  logic [EV_W-1:0]  irq_mask_q;
  logic [0:0]       ctrl_q;
  bus_state_e       bus_q;
  logic [31:0]      readdata_q;
  logic             waitrequest_q;
  logic             done_q;
  logic             bad_q;
  logic [7:0]       mem_addr_q;
  logic             irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode.
  logic [15:0]      lsw;
  logic [15:0]      msw;
  logic             bfly_go;
  logic             gf_go;
  logic [2:0]       gf_dst;
  logic [2:0]       gf_src;
  logic [3:0]       gf_imm;

  // Split the instruction into halfwords and match the two forms.
  assign lsw     = instr_word[15:0];
  assign msw     = instr_word[31:16];
  assign bfly_go = instr_valid && lsw == BFLY_LSW
                   && msw[15:8] == BFLY_MSW_TOP;
  assign gf_go   = instr_valid && lsw == GFACC_LSW
                   && msw[15:10] == GFACC_MSW_TOP;
  // Three-bit fields cannot reach register eight.
  assign gf_dst  = msw[GF_DST_LSB +: 3];
  assign gf_src  = msw[GF_SRC_LSB +: 3];
  assign gf_imm  = msw[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Butterfly lanes: 0 six low, 1 six high, 2 seven low, 3 seven high.
  logic [15:0]      lane_a   [4];
  logic [15:0]      lane_b   [4];
  logic             lane_sub [4];
  logic [16:0]      lane_sum [4];
  logic             lane_ovf [4];
  logic [15:0]      lane_sat [4];
  logic [15:0]      lane_shv [4];
  logic [15:0]      lane_res [4];
  logic             sat_en;
  logic             rnd_en;
  logic             shift_en;

  // Only imaginary halves feed the lanes; pack order select is not read.
  assign lane_a[0]   = vreg_q[0][31:16];
  assign lane_b[0]   = vreg_q[3][31:16];
  assign lane_sub[0] = 1'b0;
  assign lane_a[1]   = vreg_q[1][31:16];
  assign lane_b[1]   = vreg_q[2][31:16];
  assign lane_sub[1] = 1'b1;
  assign lane_a[2]   = vreg_q[0][31:16];
  assign lane_b[2]   = vreg_q[3][31:16];
  assign lane_sub[2] = 1'b1;
  assign lane_a[3]   = vreg_q[1][31:16];
  assign lane_b[3]   = vreg_q[2][31:16];
  assign lane_sub[3] = 1'b0;

  assign sat_en   = vector_status_reg[ST_SAT];
  assign rnd_en   = vector_status_reg[ST_RND];
  assign shift_en = ctrl_q[CTRL_SHIFT];

  // One adder, clamp, shifter and rounder per lane.
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_sum[g] = lane_sub[g]
                       ? {lane_a[g][15], lane_a[g]} - {lane_b[g][15], lane_b[g]}
                       : {lane_a[g][15], lane_a[g]} + {lane_b[g][15], lane_b[g]};
    // Overflow is seen on the full-precision result.
    assign lane_ovf[g] = lane_sum[g][16] ^ lane_sum[g][15];
    assign lane_sat[g] = (sat_en && lane_ovf[g])
                       ? (lane_sum[g][16] ? SAT_MIN : SAT_MAX)
                       : lane_sum[g][15:0];
    assign lane_shv[g] = shift_en
                       ? {lane_sat[g][15], lane_sat[g][15:1]}
                       : lane_sat[g];
    // Round half up by adding back the bit shifted out.
    assign lane_res[g] = (rnd_en && shift_en && lane_sat[g][0])
                       ? lane_shv[g] + RND_ONE
                       : lane_shv[g];
  end

  logic ovf_real;
  logic ovf_imag;

  // Lanes 0 and 2 land in real halves, 1 and 3 in imaginary halves.
  assign ovf_real = bfly_go && (lane_ovf[0] || lane_ovf[2]);
  assign ovf_imag = bfly_go && (lane_ovf[1] || lane_ovf[3]);

  ////////////////////////////////////////////////////////////////////////////
  // Galois byte accumulate.
  logic [31:0] gf_dst_word;
  logic [31:0] gf_src_word;
  logic [7:0]  gf_acc;

  assign gf_dst_word = vreg_q[gf_dst];
  assign gf_src_word = vreg_q[gf_src];

  // Fold the selected source bytes into the destination low byte.
  always_comb begin
    gf_acc = gf_dst_word[7:0];
    for (int i = 0; i < 4; i++) begin
      if (gf_imm[i]) begin
        gf_acc = gf_acc ^ gf_src_word[8*i +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then a one-cycle acknowledge.
  logic        bus_req;
  logic        wr_go;
  logic [31:0] be_mask;
  logic [31:0] rd_mux;

  assign bus_req = read || write;
  assign wr_go   = write && bus_q == BUS_ACK;
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (address <= VREG_LAST_OFS) begin
      rd_mux = vreg_q[address[4:2]];
    end else if (address == STATUS_OFS) begin
      rd_mux = {27'h0000000, vector_status_reg};
    end else if (address == IRQ_STAT_OFS) begin
      rd_mux = {29'h00000000, irq_stat_q};
    end else if (address == IRQ_MASK_OFS) begin
      rd_mux = {29'h00000000, irq_mask_q};
    end else if (address == CTRL_OFS) begin
      rd_mux = {31'h00000000, ctrl_q};
    end
  end

  // Handshake sequencer; read data is captured during the wait cycle.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bus_q         <= BUS_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q    <= 32'h0000_0000;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_q         <= BUS_ACK;
            waitrequest_q <= 1'b0;
            readdata_q    <= read ? rd_mux : 32'h0000_0000;
          end
        end
        BUS_ACK: begin
          bus_q         <= BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
        default: begin
          bus_q         <= BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector registers; an instruction overrides a bus write in the same cycle.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int r = 0; r < 8; r++) begin
        vreg_q[r] <= 32'h0000_0000;
      end
    end else begin
      if (wr_go && address <= VREG_LAST_OFS) begin
        vreg_q[address[4:2]] <= (vreg_q[address[4:2]] & ~be_mask)
                              | (writedata & be_mask);
      end
      if (bfly_go) begin
        vreg_q[6] <= {lane_res[1], lane_res[0]};
        vreg_q[7] <= {lane_res[3], lane_res[2]};
        vreg_q[0] <= word_mem_operand;
      end else if (gf_go) begin
        vreg_q[gf_dst][7:0] <= gf_acc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register; a new overflow wins over a write-one clear.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      vector_status_reg <= STATUS_RST;
    end else begin
      if (wr_go && address == STATUS_OFS && byteenable[0]) begin
        vector_status_reg[ST_SAT]   <= writedata[ST_SAT];
        vector_status_reg[ST_RND]   <= writedata[ST_RND];
        vector_status_reg[ST_COMPLEX_PACK_ORDER_SEL] <= writedata[ST_COMPLEX_PACK_ORDER_SEL];
        if (writedata[ST_REAL_OVERFLOW_FLAG]) begin
          vector_status_reg[ST_REAL_OVERFLOW_FLAG] <= 1'b0;
        end
        if (writedata[ST_IMAG_OVERFLOW_FLAG]) begin
          vector_status_reg[ST_IMAG_OVERFLOW_FLAG] <= 1'b0;
        end
      end
      // The accumulate path never reaches these assignments.
      if (ovf_real) begin
        vector_status_reg[ST_REAL_OVERFLOW_FLAG] <= 1'b1;
      end
      if (ovf_imag) begin
        vector_status_reg[ST_IMAG_OVERFLOW_FLAG] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and shift control.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_stat_q <= IRQ_RST;
      irq_mask_q <= IRQ_RST;
      ctrl_q     <= CTRL_RST;
    end else begin
      if (wr_go && byteenable[0]) begin
        if (address == IRQ_STAT_OFS) begin
          irq_stat_q <= irq_stat_q & ~writedata[EV_W-1:0];
        end else if (address == IRQ_MASK_OFS) begin
          irq_mask_q <= writedata[EV_W-1:0];
        end else if (address == CTRL_OFS) begin
          ctrl_q <= writedata[0:0];
        end
      end
      if (ovf_real) begin
        irq_stat_q[EV_REAL_OVERFLOW_FLAG] <= 1'b1;
      end
      if (ovf_imag) begin
        irq_stat_q[EV_IMAG_OVERFLOW_FLAG] <= 1'b1;
      end
      if (instr_valid && !bfly_go && !gf_go) begin
        irq_stat_q[EV_BADOP] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion pulses, operand address and interrupt line.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      done_q     <= 1'b0;
      bad_q      <= 1'b0;
      mem_addr_q <= 8'h00;
      irq_q      <= 1'b0;
    end else begin
      done_q <= bfly_go || gf_go;
      bad_q  <= instr_valid && !bfly_go && !gf_go;
      if (bfly_go) begin
        mem_addr_q <= msw[7:0];
      end
      irq_q  <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign readdata    = readdata_q;
  assign waitrequest = waitrequest_q;
  assign instr_done  = done_q;
  assign instr_bad   = bad_q;
  assign mem_addr    = mem_addr_q;
  assign irq         = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the datapath and the bus.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  logic st_wr;
  assign st_wr = wr_go && address == STATUS_OFS;

  load_word_a: assert property (bfly_go |=> instr_done
    && vreg_q[0] == $past(word_mem_operand))
    else $error("parallel word load missing");
  real_overflow_flag_set_a: assert property (bfly_go
    && (lane_ovf[0] || lane_ovf[2]) |=> vector_status_reg[ST_REAL_OVERFLOW_FLAG])
    else $error("real flag not set");
  imag_overflow_flag_set_a: assert property (bfly_go
    && (lane_ovf[1] || lane_ovf[3]) |=> vector_status_reg[ST_IMAG_OVERFLOW_FLAG])
    else $error("imag flag not set");
  flag_sticky_a: assert property (vector_status_reg[ST_REAL_OVERFLOW_FLAG]
    && !st_wr |=> vector_status_reg[ST_REAL_OVERFLOW_FLAG])
    else $error("flag lost");
  gf_flags_a: assert property (gf_go && !st_wr
    |=> $stable(vector_status_reg))
    else $error("accumulate changed flags");
  gf_upper_a: assert property (gf_go && !wr_go
    |=> vreg_q[$past(gf_dst)][31:8] == $past(gf_dst_word[31:8]))
    else $error("accumulate touched upper bits");
  gf_noimm_a: assert property (gf_go && gf_imm == 4'h0 && !wr_go
    |=> vreg_q[$past(gf_dst)] == $past(gf_dst_word))
    else $error("zero mask changed");
  sat_clamp_a: assert property (bfly_go && sat_en && !shift_en
    && lane_ovf[0] && !lane_sum[0][16] |=> vreg_q[6][15:0] == SAT_MAX)
    else $error("no clamp");
  shift_sign_a: assert property (bfly_go && sat_en && shift_en
    && !rnd_en |=> vreg_q[6][15] == vreg_q[6][14])
    else $error("not arithmetic");
  ack_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("acknowledge longer than one cycle");

  // Completion pulses, operand address, a plain sum and the interrupt lag.
  gf_done_a: assert property (gf_go |=> instr_done && !instr_bad)
    else $error("accumulate did not complete");
  bad_op_a: assert property (instr_valid && !bfly_go && !gf_go
    |=> instr_bad && !instr_done && irq_stat_q[EV_BADOP])
    else $error("unknown word not reported");
  op_addr_a: assert property (bfly_go
    |=> mem_addr == $past(msw[7:0]))
    else $error("operand address not reported");
  plain_sum_a: assert property (bfly_go && !sat_en && !shift_en
    |=> vreg_q[6][15:0] == $past(vreg_q[0][31:16] + vreg_q[3][31:16]))
    else $error("real sum wrong");
  irq_level_a: assert property (irq == $past(|(irq_stat_q & irq_mask_q)))
    else $error("interrupt line does not follow status");

  bfly_ovf_c: cover property (bfly_go && ovf_real && ovf_imag);
  gf_all_c:   cover property (gf_go && gf_imm == 4'hf);
  irq_c:      cover property (bfly_go ##1 !waitrequest ##1 irq);
  rnd_sat_c:  cover property (bfly_go && sat_en && rnd_en && shift_en);

endmodule : complex_butterfly_gf_accumulate

//--- tb/pipe_mem_model.sv
// Purpose: Pipeline and data memory model that issues words to the unit.
// Assumes: One instruction per cycle while go is high.
// Notes:   Memory words are a fixed pattern of their address.
`timescale 1ns/10ps
module pipe_mem_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        go,
  input  wire logic [31:0] word,
  output logic             instr_valid,
  output logic [31:0]      instr_word,
  output logic [31:0]      word_mem_operand
);
  logic [31:0] last_q;

  // Memory contents depend only on the word address.
  function automatic logic [31:0] mem_word(input logic [7:0] a);
    return {a, ~a, a ^ 8'h5a, 8'hc3};
  endfunction : mem_word

  ////////////////////////////////////////
  // Three-bit register fields can never name register eight.
  assign instr_valid = go;
  assign instr_word = word;
  // Between issues the operand bus shows the inverse of its last value.
  assign word_mem_operand = go ? mem_word(word[23:16]) : ~last_q;

  // Remember the last operand so the idle bus never repeats it.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      last_q <= 32'h0;
    end else if (go) begin
      last_q <= mem_word(word[23:16]);
    end
  end
endmodule : pipe_mem_model

//--- tb/complex_butterfly_gf_accumulate_tb_top.sv
// Purpose: Self-checking bench for the butterfly and Galois unit.
// Assumes: Registers are reached over Avalon-MM; the model issues words.
// Notes:   A row table covers butterfly modes; hand tests follow.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module complex_butterfly_gf_accumulate_tb_top;
  import cbgf_pkg::*;
  typedef struct {
    logic [2:0]  st;
    logic        sh;
    logic [15:0] h [4];
    logic [31:0] e6;
    logic [31:0] e7;
    logic [1:0]  flg;
  } row_s;
  logic        clock, rst_b, read, write, go, instr_valid;
  logic        instr_done, instr_bad, irq, waitrequest;
  logic [5:0]  address;
  logic [3:0]  byteenable;
  logic [7:0]  mem_addr, a;
  logic [31:0] writedata, readdata, word, instr_word, word_mem_operand;
  logic [31:0] d, st0;
  int          num_errors, num_checks;
  row_s        rows [8] = '{
    '{3'h0, 1'h0, '{16'h0010, 16'h0020, 16'h0005, 16'h0003},
      32'h001b0013, 32'h0025000d, 2'h0},
    '{3'h1, 1'h1, '{16'hfff1, 16'h0007, 16'h0002, 16'h0002},
      32'h0002fff9, 32'h0004fff7, 2'h0},
    '{3'h6, 1'h1, '{16'hfff1, 16'h0007, 16'h0002, 16'h0002},
      32'h0003fffa, 32'h0005fff8, 2'h0},
    '{3'h1, 1'h0, '{16'h7000, 16'h8000, 16'h0001, 16'h2000},
      32'h80007fff, 32'h80015000, 2'h3},
    '{3'h4, 1'h0, '{16'h7000, 16'h8000, 16'h0001, 16'h2000},
      32'h7fff9000, 32'h80015000, 2'h3},
    '{3'h3, 1'h1, '{16'h7000, 16'h8000, 16'h0001, 16'h2000},
      32'hc0004000, 32'hc0012800, 2'h3},
    '{3'h0, 1'h0, '{16'h0001, 16'h7fff, 16'h0001, 16'h0001},
      32'h7ffe0002, 32'h80000000, 2'h2},
    '{3'h0, 1'h0, '{16'h8000, 16'h0002, 16'h0001, 16'h0001},
      32'h00018001, 32'h00037fff, 2'h1}};

  // Free-running clock of 100 ns period.
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end

  complex_butterfly_gf_accumulate complex_butterfly_gf_accumulate_inst (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .word_mem_operand(word_mem_operand), .instr_done(instr_done),
    .instr_bad(instr_bad), .mem_addr(mem_addr), .irq(irq));

  pipe_mem_model pipe_mem_model_inst (
    .clock(clock), .rst_b(rst_b), .go(go), .word(word),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .word_mem_operand(word_mem_operand));

  ////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // One bus transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [5:0] ad,
                     input logic [31:0] wd, output logic [31:0] rd_v);
    int n;
    address <= ad;
    writedata <= wd;
    write <= wr;
    read <= ~wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'h0 && n < 20);
    if (n >= 20) begin
      num_errors++;
      results();
    end else begin
      rd_v = readdata;
      write <= 1'h0;
      read <= 1'h0;
      @(posedge clock);
    end
  endtask : bus

  task automatic wr(input logic [5:0] ad, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'h1, ad, wd, x);
  endtask : wr

  task automatic rd(input logic [5:0] ad, output logic [31:0] v);
    bus(1'h0, ad, 32'h0, v);
  endtask : rd

  // Issues one word and checks the completion pulses.
  task automatic issue(input logic [31:0] w, input logic good);
    go <= 1'h1;
    word <= w;
    @(posedge clock);
    go <= 1'h0;
    @(posedge clock);
    `CHK(instr_done, good)
    `CHK(instr_bad, ~good)
  endtask : issue

  // Sets the modes, clears the flags and loads registers zero to three.
  task automatic load_row(input row_s r);
    wr(STATUS_OFS, {27'h0, 2'h3, r.st});
    wr(CTRL_OFS, {31'h0, r.sh});
    for (int k = 0; k < 4; k++) wr(6'(4 * k), {r.h[k], 16'hbeef});
  endtask : load_row

  function automatic logic [7:0] gf_exp(input logic [3:0] m);
    logic [7:0] x;
    x = 8'ha5 ^ (m[0] ? 8'h15 : 8'h00) ^ (m[1] ? 8'h2e : 8'h00);
    return x ^ (m[2] ? 8'h4a : 8'h00) ^ (m[3] ? 8'h8c : 8'h00);
  endfunction : gf_exp

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results();
  end

  ////////////////////////////////////////
  // Main sequence: reset, row table, then the awkward cases.
  initial begin
    rst_b <= 1'h0;
    read <= 1'h0;
    write <= 1'h0;
    go <= 1'h0;
    address <= 6'h00;
    writedata <= 32'h0;
    byteenable <= 4'hf;
    word <= 32'h0;
    num_errors = 0;
    num_checks = 0;
    repeat (10) @(posedge clock);
    rst_b <= 1'h1;
    @(posedge clock);
    rd(CTRL_OFS, d);
    `CHK(d, 32'h1)
    rd(STATUS_OFS, d);
    `CHK(d, 32'h0)
    rd(6'h18, d);
    `CHK(d, 32'h0)
    $display("reset test done");
    foreach (rows[i]) begin
      load_row(rows[i]);
      a = 8'(i * 37 + 5);
      issue({BFLY_MSW_TOP, a, BFLY_LSW}, 1'h1);
      `CHK(mem_addr, a)
      rd(6'h18, d);
      `CHK(d, rows[i].e6)
      rd(6'h1c, d);
      `CHK(d, rows[i].e7)
      rd(VREG_BASE_OFS, d);
      `CHK(d, {a, ~a, a ^ 8'h5a, 8'hc3})
      rd(STATUS_OFS, d);
      `CHK(d, {27'h0, rows[i].flg, rows[i].st})
    end
    $display("row table test done");
    wr(6'h10, 32'h8c4a2e15);
    rd(STATUS_OFS, st0);
    for (int i = 0; i < 16; i++) begin
      wr(6'h14, 32'ha5a5a5a5);
      issue({6'h00, 3'h5, 3'h4, 4'(i), GFACC_LSW}, 1'h1);
      rd(6'h14, d);
      `CHK(d, {24'ha5a5a5, gf_exp(4'(i))})
    end
    rd(STATUS_OFS, d);
    `CHK(d, st0)
    $display("accumulate test done");
    load_row(rows[0]);
    go <= 1'h1;
    word <= {BFLY_MSW_TOP, 8'h40, BFLY_LSW};
    @(posedge clock);
    word <= {6'h00, 3'h2, 3'h6, 4'h1, GFACC_LSW};
    @(posedge clock);
    go <= 1'h0;
    @(posedge clock);
    rd(6'h08, d);
    `CHK(d, 32'h0005befc)
    $display("back to back test done");
    rd(IRQ_STAT_OFS, d);
    `CHK(d, 32'h3)
    wr(IRQ_STAT_OFS, 32'h7);
    wr(IRQ_MASK_OFS, 32'h4);
    issue({8'h08, 8'h00, BFLY_LSW}, 1'h0);
    rd(IRQ_STAT_OFS, d);
    `CHK(d, 32'h4)
    `CHK(irq, 1'h1)
    wr(IRQ_MASK_OFS, 32'h0);
    @(posedge clock);
    `CHK(irq, 1'h0)
    wr(IRQ_MASK_OFS, 32'h4);
    @(posedge clock);
    `CHK(irq, 1'h1)
    wr(IRQ_STAT_OFS, 32'h4);
    @(posedge clock);
    `CHK(irq, 1'h0)
    wr(6'h30, 32'hffffffff);
    rd(6'h30, d);
    `CHK(d, 32'h0)
    $display("interrupt and unmapped test done");
    results();
  end
endmodule : complex_butterfly_gf_accumulate_tb_top
